// >>> src/pmtr_pkg.sv
// Constants and types shared by the program-memory table-read block.
// Assumes a single 25 MHz system clock and an active-low async reset.
// Behaviour
// (RULE_01) The program store holds 16-bit words, 4K to 16K of them.
// (RULE_02) Instruction fetch addresses come from the program counter.
// (RULE_03) After reset execution starts at program address zero.
// (RULE_04) A table read address is built from the low and high pointers.
// (RULE_05) A table read writes the low byte out and the high byte inside.
// (RULE_06) High-byte bits with no stored bit behind them read as zero.
// (RULE_07) Standard table reads reach sector zero only, extended any sector.
// (RULE_08) For paged reads the low pointer picks a word in the high page.
// (RULE_09) Every table read takes exactly two instruction cycles.
// (RULE_10) Software masks interrupts around shared table high-byte use.
// (RULE_11) Programming moves data both ways on one pin with a host clock.
// (RULE_12) On the emulation chip the shared pin functions are disabled.
// (RULE_13) The debug data pin is two-way and the debug clock input only.
// (RULE_14) A page is 256 words, so a low byte only selects within a page.
// (RULE_15) Above 8K words a bank-select bit extends the fetch address.
// (RULE_16) Last-page reads ignore the high pointer and use the last page.
// (RULE_17) The table high-data register can be read and written by software.
package pmtr_pkg;

  // ==========================================================================
  // Program store geometry
  localparam int PMTR_WORD_W      = 16;
  localparam int PMTR_DEPTH_MIN   = 4096;
  localparam int PMTR_DEPTH_MAX   = 16384;
  localparam int PMTR_BANK_LIMIT  = 8192;
  localparam int PMTR_PAGE_WORDS  = 256;
  localparam int PMTR_PAGE_BITS   = 8;
  localparam int PMTR_PC_W        = 13;
  localparam int PMTR_FADDR_W     = 14;
  localparam logic [PMTR_PC_W-1:0] PMTR_RESET_VECTOR = 13'h0000;

  // ==========================================================================
  // Data-memory destination layout
  localparam int PMTR_DM_ADDR_W   = 11;
  localparam int PMTR_SECTOR_LSB  = 8;
  localparam logic [2:0] PMTR_SECTOR_ZERO = 3'h0;

  // ==========================================================================
  // Timing: four system clocks form one instruction cycle.
  localparam int PMTR_CLK_MHZ     = 25;
  localparam int PMTR_PHASES      = 4;
  localparam int PMTR_TBL_ICYC    = 2;
  localparam int PMTR_TBL_CLKS    = PMTR_PHASES * PMTR_TBL_ICYC;
  localparam logic [1:0] PMTR_LAST_PHASE = 2'h3;

  // ==========================================================================
  // Serial programming frame: command, address, turnaround, data.
  localparam logic [4:0] PMTR_SER_ADDR_END = 5'h0e;
  localparam logic [4:0] PMTR_SER_TURN     = 5'h0f;
  localparam logic [4:0] PMTR_SER_LAST     = 5'h1f;

  typedef enum logic [1:0] {
    PMTR_TABLE_READ_PAGED,
    PMTR_TABLE_READ_LAST_PAGE,
    PMTR_EXT_TABLE_READ_PAGED,
    PMTR_EXT_TABLE_READ_LAST_PAGE
  } pmtr_kind_t;

  typedef enum logic [0:0] {
    PMTR_TBL_IDLE,
    PMTR_TBL_RUN
  } pmtr_tbl_state_t;

endpackage : pmtr_pkg

// >>> src/pmtr_serial_prog.sv
// Serial in-circuit programming port of the program store.
// Assumes the programmer clocks bits on the shared pins; pins are async.
module pmtr_serial_prog
  import pmtr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    sdat_i,
  input  wire logic                    sclk_i,
  output logic                         sdat_o,
  output logic                         sdat_oe,
  output logic                         wr_en,
  output logic [PMTR_FADDR_W-1:0]      addr,
  output logic [PMTR_WORD_W-1:0]       wr_data,
  input  wire logic [PMTR_WORD_W-1:0]  rd_data,
  output logic                         active
);

  // ==========================================================================
  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [2:0] clk_sync_ff;
  logic [2:0] dat_sync_ff;
  logic       clk_lvl_ff;
  logic       dat_lvl_ff;
  logic       sclk_rise;
  logic       dat_now;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_sync_ff <= 3'h0;
      dat_sync_ff <= 3'h0;
      clk_lvl_ff  <= 1'b0;
      dat_lvl_ff  <= 1'b0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], sclk_i};
      dat_sync_ff <= {dat_sync_ff[1:0], sdat_i};
      if (clk_sync_ff[1] == clk_sync_ff[2]) clk_lvl_ff <= clk_sync_ff[2];
      if (dat_sync_ff[1] == dat_sync_ff[2]) dat_lvl_ff <= dat_sync_ff[2];
    end
  end

  assign sclk_rise = (clk_sync_ff[1] == clk_sync_ff[2]) && clk_sync_ff[2]
                     && !clk_lvl_ff;
  assign dat_now   = (dat_sync_ff[1] == dat_sync_ff[2]) ? dat_sync_ff[2]
                                                        : dat_lvl_ff;

  // ==========================================================================
  // Frame: bit 0 command (1 write), 1..14 address, 15 turnaround, 16..31 data.
  logic [4:0]             bit_ff;
  logic                   cmd_wr_ff;
  logic [PMTR_WORD_W-1:0] sh_ff;
  logic [PMTR_WORD_W-1:0] out_ff;
  logic                   oe_ff;
  logic                   wr_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_ff    <= 5'h00;
      cmd_wr_ff <= 1'b0;
      sh_ff     <= 16'h0000;
      out_ff    <= 16'h0000;
      oe_ff     <= 1'b0;
      wr_ff     <= 1'b0;
      addr      <= 14'h0000;
    end else begin
      wr_ff <= 1'b0;
      if (sclk_rise) begin
        bit_ff <= bit_ff + 5'h01;
        sh_ff  <= {sh_ff[PMTR_WORD_W-2:0], dat_now};
        if (bit_ff == 5'h00) cmd_wr_ff <= dat_now;
        if (bit_ff == PMTR_SER_ADDR_END)
          addr <= {sh_ff[PMTR_FADDR_W-2:0], dat_now};
        // Read data goes out on the single data pin after turnaround.
        if (bit_ff == PMTR_SER_TURN && !cmd_wr_ff) begin  // RULE_11
          out_ff <= rd_data;
          oe_ff  <= 1'b1;                                  // RULE_13
        end else if (oe_ff) begin
          out_ff <= {out_ff[PMTR_WORD_W-2:0], 1'b0};
        end
        if (bit_ff == PMTR_SER_LAST) begin
          oe_ff <= 1'b0;
          wr_ff <= cmd_wr_ff;                              // RULE_11
        end
      end
    end
  end

  assign wr_data = sh_ff;
  assign wr_en   = wr_ff;
  assign sdat_o  = out_ff[PMTR_WORD_W-1];
  assign sdat_oe = oe_ff;
  assign active  = (bit_ff != 5'h00) || oe_ff;

endmodule : pmtr_serial_prog

// >>> src/pmtr_core.sv
// Program store, program counter and table-read engine of the MCU core.
// Assumes the CPU core issues table reads and pointer writes as pulses.
module pmtr_core
  import pmtr_pkg::*;
#(
  parameter int DEPTH            = PMTR_DEPTH_MIN,
  parameter int STORED_HIGH_BITS = 8,
  parameter bit EV_CHIP          = 1'b0
)
(
  input  wire logic                      CLK,
  input  wire logic                      NRST,
  input  wire logic                      PC_LOAD,
  input  wire logic [PMTR_PC_W-1:0]      PC_LOAD_VAL,
  input  wire logic                      PROGRAM_BANK_SELECT,
  output logic [PMTR_FADDR_W-1:0]        FETCH_ADDR,
  output logic [PMTR_WORD_W-1:0]         INSTR_WORD,
  output logic                           INSTR_VALID,
  input  wire logic                      TBL_REQ,
  input  wire pmtr_kind_t                TBL_KIND,
  input  wire logic [PMTR_DM_ADDR_W-1:0] TBL_DEST,
  input  wire logic                      TBLP_WR,
  input  wire logic                      TBHP_WR,
  input  wire logic                      TDH_WR,
  input  wire logic [7:0]                SW_WDATA,
  output logic [7:0]                     TABLE_DATA_HIGH,
  output logic                           TBL_BUSY,
  output logic                           DM_WR,
  output logic [PMTR_DM_ADDR_W-1:0]      DM_ADDR,
  output logic [7:0]                     DM_WDATA,
  input  wire logic                      DEBUG_SERIAL_DATA_I,
  output logic                           DEBUG_SERIAL_DATA_O,
  output logic                           DEBUG_SERIAL_DATA_OE,
  input  wire logic                      DEBUG_SERIAL_CLOCK,
  output logic                           PROG_ACTIVE,
  output logic                           SHARED_PIN_FUNC_EN
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [7:0] HIGH_MASK =
    8'((9'h001 << STORED_HIGH_BITS) - 9'h001);

  // ==========================================================================
  // Address functions
  function automatic logic [AW-1:0] fetch_addr_f(
    input logic                 bank,
    input logic [PMTR_PC_W-1:0] pc
  );
    logic [PMTR_FADDR_W-1:0] full;
    full = {bank, pc};
    // Only parts beyond 8K words carry the bank bit into the address.
    if (DEPTH > PMTR_BANK_LIMIT) fetch_addr_f = AW'(full);   // RULE_15
    else                         fetch_addr_f = AW'(pc);     // RULE_02
  endfunction : fetch_addr_f

  function automatic logic [AW-1:0] table_addr_f(
    input pmtr_kind_t kind,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [AW-PMTR_PAGE_BITS-1:0] page;
    page = hi[AW-PMTR_PAGE_BITS-1:0];                        // RULE_04
    if (kind == PMTR_TABLE_READ_LAST_PAGE ||
        kind == PMTR_EXT_TABLE_READ_LAST_PAGE)
      page = '1;                                             // RULE_16
    table_addr_f = {page, lo};                     // RULE_08 RULE_14
  endfunction : table_addr_f

  function automatic logic is_ext_f(input pmtr_kind_t kind);
    is_ext_f = (kind == PMTR_EXT_TABLE_READ_PAGED) ||
               (kind == PMTR_EXT_TABLE_READ_LAST_PAGE);
  endfunction : is_ext_f

  // ==========================================================================
  // Program store; 16-bit words, depth set per variant.
  logic [PMTR_WORD_W-1:0]  mem_q [DEPTH];                    // RULE_01
  logic                    prog_wr;
  logic [PMTR_FADDR_W-1:0] prog_addr;
  logic [PMTR_WORD_W-1:0]  prog_wdata;
  logic [PMTR_WORD_W-1:0]  prog_rdata;

  always_ff @(posedge CLK) begin
    if (prog_wr) mem_q[prog_addr[AW-1:0]] <= prog_wdata;
  end

  assign prog_rdata = mem_q[prog_addr[AW-1:0]];

  // The emulation chip reuses the debug pins for programming as well.
  pmtr_serial_prog u_prog (
    .clk     (CLK),
    .nrst    (NRST),
    .sdat_i  (DEBUG_SERIAL_DATA_I),
    .sclk_i  (DEBUG_SERIAL_CLOCK),
    .sdat_o  (DEBUG_SERIAL_DATA_O),
    .sdat_oe (DEBUG_SERIAL_DATA_OE),
    .wr_en   (prog_wr),
    .addr    (prog_addr),
    .wr_data (prog_wdata),
    .rd_data (prog_rdata),
    .active  (PROG_ACTIVE)
  );

  // Normal pin functions yield while programming, and always on the EV chip.
  assign SHARED_PIN_FUNC_EN = !EV_CHIP && !PROG_ACTIVE;      // RULE_12

  // ==========================================================================
  // Instruction cycle phases and program counter
  logic [1:0]           phase_ff;
  logic [PMTR_PC_W-1:0] pc_ff;
  pmtr_tbl_state_t      state_ff;

  assign TBL_BUSY = (state_ff == PMTR_TBL_RUN);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) phase_ff <= 2'h0;
    else       phase_ff <= phase_ff + 2'h1;
  end

  // A running table read freezes the counter: its second cycle is a dummy.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pc_ff <= PMTR_RESET_VECTOR;                            // RULE_03
    end else if (PC_LOAD) begin
      pc_ff <= PC_LOAD_VAL;
    end else if (phase_ff == PMTR_LAST_PHASE && !TBL_BUSY) begin
      pc_ff <= pc_ff + 13'h0001;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      INSTR_WORD  <= 16'h0000;
      INSTR_VALID <= 1'b0;
      FETCH_ADDR  <= 14'h0000;
    end else begin
      INSTR_VALID <= 1'b0;
      if (phase_ff == 2'h0 && !TBL_BUSY) begin
        INSTR_WORD  <= mem_q[fetch_addr_f(PROGRAM_BANK_SELECT, pc_ff)];
        FETCH_ADDR  <= PMTR_FADDR_W'(fetch_addr_f(PROGRAM_BANK_SELECT,
                                                  pc_ff));
        INSTR_VALID <= 1'b1;                                 // RULE_02
      end
    end
  end

  // ==========================================================================
  // Table pointers
  logic [7:0] tblp_ff;
  logic [7:0] tbhp_ff;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tblp_ff <= 8'h00;
      tbhp_ff <= 8'h00;
    end else begin
      if (TBLP_WR) tblp_ff <= SW_WDATA;
      if (TBHP_WR) tbhp_ff <= SW_WDATA;
    end
  end

  // ==========================================================================
  // Table-read engine: busy for two instruction cycles, then one write.
  logic [2:0]                cnt_ff;
  logic [AW-1:0]             addr_ff;
  logic [PMTR_DM_ADDR_W-1:0] dest_ff;
  logic [PMTR_WORD_W-1:0]    word_ff;
  logic                      finish;
  logic                      tbl_start;

  assign tbl_start = TBL_REQ && !TBL_BUSY;
  assign finish    = TBL_BUSY && (cnt_ff == 3'(PMTR_TBL_CLKS - 1));

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= PMTR_TBL_IDLE;
      cnt_ff   <= 3'h0;
      addr_ff  <= '0;
      dest_ff  <= 11'h000;
    end else begin
      case (state_ff)
        PMTR_TBL_IDLE: begin
          if (tbl_start) begin
            state_ff <= PMTR_TBL_RUN;
            cnt_ff   <= 3'h0;
            addr_ff  <= table_addr_f(TBL_KIND, tblp_ff, tbhp_ff);
            // Standard reads carry only an in-sector offset.
            if (is_ext_f(TBL_KIND)) dest_ff <= TBL_DEST;     // RULE_07
            else dest_ff <= {PMTR_SECTOR_ZERO, TBL_DEST[7:0]}; // RULE_07
          end
        end
        PMTR_TBL_RUN: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (finish) state_ff <= PMTR_TBL_IDLE;             // RULE_09
        end
        default: state_ff <= PMTR_TBL_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) word_ff <= 16'h0000;
    else if (TBL_BUSY && cnt_ff == 3'h0) word_ff <= mem_q[addr_ff];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DM_WR    <= 1'b0;
      DM_ADDR  <= 11'h000;
      DM_WDATA <= 8'h00;
    end else begin
      DM_WR <= finish;
      if (finish) begin
        DM_ADDR  <= dest_ff;                                 // RULE_05
        DM_WDATA <= word_ff[7:0];                            // RULE_05
      end
    end
  end

  // Hardware completion wins over a software write in the same cycle;
  // interrupt code must save and restore this register itself.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) TABLE_DATA_HIGH <= 8'h00;
    else if (finish)
      TABLE_DATA_HIGH <= word_ff[15:8] & HIGH_MASK;  // RULE_05 RULE_06
    else if (TDH_WR)
      TABLE_DATA_HIGH <= SW_WDATA & HIGH_MASK;               // RULE_17
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic seen_fetch_ff;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)            seen_fetch_ff <= 1'b0;
    else if (INSTR_VALID) seen_fetch_ff <= 1'b1;
  end

  sequence s_tbl_take;
    tbl_start;
  endsequence
  sequence s_tbl_run;
    TBL_BUSY [*8] ##1 (DM_WR && !TBL_BUSY);
  endsequence

  a_tbl_two_cycles: assert property (s_tbl_take |=> s_tbl_run) // RULE_09
    else $error("table read did not finish in two instruction cycles");
  a_reset_vector: assert property (                            // RULE_03
    (INSTR_VALID && !seen_fetch_ff) |-> FETCH_ADDR == 14'h0000)
    else $error("first fetch after reset not at address zero");
  a_low_byte_out: assert property (                            // RULE_05
    DM_WR |-> DM_WDATA == word_ff[7:0] && $past(finish))
    else $error("data-memory write does not carry the low byte");
  a_high_mask: assert property (                               // RULE_06
    (TABLE_DATA_HIGH & ~HIGH_MASK) == 8'h00)
    else $error("unstored high-byte bit reads as one");
  a_std_sector: assert property (                              // RULE_07
    (tbl_start && !is_ext_f(TBL_KIND)) |-> ##9
      (DM_WR && DM_ADDR[10:8] == PMTR_SECTOR_ZERO))
    else $error("standard table read left sector zero");
  a_last_page: assert property (                               // RULE_16
    (tbl_start && TBL_KIND == PMTR_TABLE_READ_LAST_PAGE) |=>
      (addr_ff == {{(AW-8){1'b1}}, $past(tblp_ff)}))
    else $error("last-page read used the wrong page");
  a_paged_addr: assert property (                              // RULE_08
    (tbl_start && TBL_KIND == PMTR_TABLE_READ_PAGED) |=>
      (addr_ff == {$past(tbhp_ff[AW-9:0]), $past(tblp_ff)}))
    else $error("paged read address not built from both pointers");
  a_tdh_write: assert property (                               // RULE_17
    (TDH_WR && !finish) |=> TABLE_DATA_HIGH == ($past(SW_WDATA) & HIGH_MASK))
    else $error("software write to table high data lost");
  a_pc_hold: assert property (                                 // RULE_09
    (TBL_BUSY && !PC_LOAD) |=> $stable(pc_ff))
    else $error("program counter moved during table read");
  a_shared_pins: assert property (                             // RULE_12
    (EV_CHIP || PROG_ACTIVE) |-> !SHARED_PIN_FUNC_EN)
    else $error("shared pin function active on emulation chip");

endmodule : pmtr_core

// >>> verification/testbench.sv
// Self-checking bench for the program-memory table-read block.
// Assumes pmtr_pkg and pmtr_core are compiled first; the bench drives
// every pin itself, including the programmer side of the serial pins.
module testbench
  import pmtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  localparam int         STORED  = 6;
  localparam logic [7:0] HI_MASK = 8'hff >> (8 - STORED);

  logic                      clk;
  logic                      nrst;
  logic                      pc_load;
  logic [PMTR_PC_W-1:0]      pc_load_val;
  logic                      bank_sel;
  logic [PMTR_FADDR_W-1:0]   fetch_addr;
  logic [PMTR_WORD_W-1:0]    instr_word;
  logic                      instr_valid;
  logic                      tbl_req;
  pmtr_kind_t                tbl_kind;
  logic [PMTR_DM_ADDR_W-1:0] tbl_dest;
  logic                      tblp_wr;
  logic                      tbhp_wr;
  logic                      tdh_wr;
  logic [7:0]                sw_wdata;
  logic [7:0]                tdh;
  logic                      busy;
  logic                      dm_wr;
  logic [PMTR_DM_ADDR_W-1:0] dm_addr;
  logic [7:0]                dm_wdata;
  logic                      sd_o;
  logic                      sd_oe;
  logic                      sd_wire;
  logic                      sck;
  logic                      tb_oe;
  logic                      tb_val;
  logic                      prog_active;
  logic                      shared_en;
  int                        error_cnt;
  int                        checked;
  logic [11:0]               pa [4] = '{12'h000, 12'h001, 12'h306, 12'hf06};
  logic [15:0]               pw [4] = '{16'h1234, 16'h5678, 16'hffc3,
                                        16'hbe1a};

  // The line has no pull, so a released pin shows the inverse of the last
  // driven value rather than a level the design might happen to expect.
  assign sd_wire = sd_oe ? sd_o : (tb_oe ? tb_val : ~tb_val);

  pmtr_core #(
    .DEPTH            (4096),
    .STORED_HIGH_BITS (STORED),
    .EV_CHIP          (1'b0)
  ) u_dut (
    .CLK                  (clk),
    .NRST                 (nrst),
    .PC_LOAD              (pc_load),
    .PC_LOAD_VAL          (pc_load_val),
    .PROGRAM_BANK_SELECT  (bank_sel),
    .FETCH_ADDR           (fetch_addr),
    .INSTR_WORD           (instr_word),
    .INSTR_VALID          (instr_valid),
    .TBL_REQ              (tbl_req),
    .TBL_KIND             (tbl_kind),
    .TBL_DEST             (tbl_dest),
    .TBLP_WR              (tblp_wr),
    .TBHP_WR              (tbhp_wr),
    .TDH_WR               (tdh_wr),
    .SW_WDATA             (sw_wdata),
    .TABLE_DATA_HIGH      (tdh),
    .TBL_BUSY             (busy),
    .DM_WR                (dm_wr),
    .DM_ADDR              (dm_addr),
    .DM_WDATA             (dm_wdata),
    .DEBUG_SERIAL_DATA_I  (sd_wire),
    .DEBUG_SERIAL_DATA_O  (sd_o),
    .DEBUG_SERIAL_DATA_OE (sd_oe),
    .DEBUG_SERIAL_CLOCK   (sck),
    .PROG_ACTIVE          (prog_active),
    .SHARED_PIN_FUNC_EN   (shared_en)
  );

  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // One strobe per call; 0 low pointer, 1 high pointer, 2 high-data.
  // The strobes stay low across one edge so that back-to-back calls never
  // drive the same strobe twice in one time step.
  task automatic sw_wr(input int which, input logic [7:0] v);
    sw_wdata = v;
    tblp_wr  = (which == 0);
    tbhp_wr  = (which == 1);
    tdh_wr   = (which == 2);
    tick(1);
    tblp_wr = 1'b0;
    tbhp_wr = 1'b0;
    tdh_wr  = 1'b0;
    tick(1);
  endtask : sw_wr

  // Each serial clock level lasts 8 system clocks so the synchroniser
  // always sees it; the serial clock rests low between frames.
  task automatic ser_frame(input logic wr, input logic [13:0] a,
                           input logic [15:0] d, output logic [15:0] q);
    logic [31:0] frame;
    frame = {wr, a, 1'b0, d};
    q = '0;
    for (int i = 0; i < 32; i++) begin
      tb_oe = (i < 15) || (wr && i > 15);
      if (tb_oe) begin
        tb_val = frame[31-i];
      end
      tick(8);
      if (i >= 16) begin
        q = {q[14:0], sd_wire};
      end
      if (i == 20) begin
        chk_b(sd_oe, ~wr);
        chk_b(prog_active, 1'b1);
        chk_b(shared_en, 1'b0);
      end
      sck = 1'b1;
      tick(8);
      sck = 1'b0;
    end
    tb_oe = 1'b0;
    tick(8);
    chk_b(sd_oe, 1'b0);
    chk_b(prog_active, 1'b0);
    chk_b(shared_en, 1'b1);
  endtask : ser_frame

  task automatic tbl_rd(input int k, input logic [15:0] w, input bit refuse);
    logic [10:0] exp_dest;
    exp_dest = k[1] ? 11'h5c7 : 11'h0c7;
    tbl_kind = pmtr_kind_t'(k[1:0]);
    tbl_dest = 11'h5c7;
    tbl_req  = 1'b1;
    tick(1);
    // Busy stands for the eight clocks after the taking edge; a request
    // raised in the middle of them must be ignored.
    for (int c = 0; c < 8; c++) begin
      chk_b(busy, 1'b1);
      chk_b(dm_wr, 1'b0);
      tbl_req = refuse && (c == 2);
      tick(1);
    end
    chk_b(dm_wr, 1'b1);
    chk_b(busy, 1'b0);
    chk_w({5'h00, dm_addr}, {5'h00, exp_dest});
    chk_w({8'h00, dm_wdata}, {8'h00, w[7:0]});
    chk_w({8'h00, tdh}, {8'h00, w[15:8] & HI_MASK});
  endtask : tbl_rd

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    repeat (5) @(posedge clk);
    #1;
    chk_b(busy, 1'b0);
    chk_b(dm_wr, 1'b0);
    chk_b(sd_oe, 1'b0);
    nrst = 1'b1;
    tick(1);
    chk_b(instr_valid, 1'b1);
    chk_w({2'h0, fetch_addr}, 16'h0000);
    tick(4);
    chk_w({2'h0, fetch_addr}, 16'h0001);
  endtask : t_reset

  task automatic t_load;
    logic [15:0] q;
    for (int i = 0; i < 4; i++) begin
      ser_frame(1'b1, {2'h0, pa[i]}, pw[i], q);
    end
  endtask : t_load

  // The load lands on the increment edge, so it must win over the step.
  task automatic t_fetch;
    for (int i = 0; i < 8 && instr_valid !== 1'b1; i++) begin
      tick(1);
    end
    chk_b(instr_valid, 1'b1);
    tick(2);
    pc_load = 1'b1;
    tick(1);
    pc_load = 1'b0;
    tick(1);
    chk_b(instr_valid, 1'b1);
    chk_w({2'h0, fetch_addr}, 16'h0000);
    chk_w(instr_word, pw[0]);
    tick(4);
    chk_w({2'h0, fetch_addr}, 16'h0001);
    chk_w(instr_word, pw[1]);
  endtask : t_fetch

  // Reads run back to back; upper high-pointer bits lie beyond the store.
  task automatic t_table;
    sw_wr(0, 8'h06);
    sw_wr(1, 8'h13);
    for (int k = 0; k < 4; k++) begin
      tbl_rd(k, k[0] ? pw[3] : pw[2], k == 1);
    end
    tick(1);
    chk_b(dm_wr, 1'b0);
    chk_b(busy, 1'b0);
  endtask : t_table

  task automatic t_tdh;
    sw_wr(2, 8'hff);
    tick(1);
    chk_w({8'h00, tdh}, {8'h00, 8'hff & HI_MASK});
    sw_wr(2, 8'h81);
    tick(1);
    chk_w({8'h00, tdh}, {8'h00, 8'h81 & HI_MASK});
  endtask : t_tdh

  task automatic t_readback;
    logic [15:0] q;
    ser_frame(1'b0, {2'h0, pa[2]}, 16'h0000, q);
    chk_w(q, pw[2]);
  endtask : t_readback

  // A reset in mid-run must restart fetching at the reset entry while the
  // program store keeps its contents.
  task automatic t_rereset;
    nrst = 1'b0;
    tick(2);
    chk_w({8'h00, tdh}, 16'h0000);
    chk_b(prog_active, 1'b0);
    nrst = 1'b1;
    tick(1);
    chk_b(instr_valid, 1'b1);
    chk_w({2'h0, fetch_addr}, 16'h0000);
    chk_w(instr_word, pw[0]);
  endtask : t_rereset

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever begin
      #20 clk = ~clk;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    nrst        = 1'b0;
    pc_load     = 1'b0;
    pc_load_val = '0;
    bank_sel    = 1'b1;
    tbl_req     = 1'b0;
    tbl_kind    = PMTR_TABLE_READ_PAGED;
    tbl_dest    = '0;
    tblp_wr     = 1'b0;
    tbhp_wr     = 1'b0;
    tdh_wr      = 1'b0;
    sw_wdata    = '0;
    sck         = 1'b0;
    tb_oe       = 1'b0;
    tb_val      = 1'b0;
    error_cnt   = 0;
    checked     = 0;
    t_reset();
    t_load();
    t_fetch();
    t_table();
    t_tdh();
    t_readback();
    t_rereset();
    complete_run();
  end

endmodule : testbench
